// File: include/erb_pkg.sv
// shared types, sizes and helpers for the embedded ram block
`default_nettype none
package erb_pkg;

   typedef enum logic [1:0] {
      ERB_SMALL  = 2'h0,
      ERB_MEDIUM = 2'h1,
      ERB_LARGE  = 2'h3
   } erb_size_type;

   typedef enum logic [1:0] {
      ERB_TRUE_DP   = 2'h0,
      ERB_SIMPLE_DP = 2'h1,
      ERB_SINGLE    = 2'h3,
      ERB_TWO_SP    = 2'h2
   } erb_mode_type;

   // storage bits with and without the parity bit of each byte
   localparam int ERB_SMALL_PAR_BITS  = 576;
   localparam int ERB_SMALL_BITS      = 512;
   localparam int ERB_MEDIUM_PAR_BITS = 4608;
   localparam int ERB_MEDIUM_BITS     = 4096;
   localparam int ERB_LARGE_PAR_BITS  = 589824;
   localparam int ERB_LARGE_BITS      = 524288;
   localparam int ERB_PAR_UNIT        = 9;

   function automatic int erb_cap(input erb_size_type size,
                                  input bit           par);
      case (size)
         ERB_SMALL:  erb_cap = par ? ERB_SMALL_PAR_BITS : ERB_SMALL_BITS;
         ERB_LARGE:  erb_cap = par ? ERB_LARGE_PAR_BITS : ERB_LARGE_BITS;
         default:    erb_cap = par ? ERB_MEDIUM_PAR_BITS : ERB_MEDIUM_BITS;
      endcase
   endfunction : erb_cap

   function automatic bit erb_par(input int wa,
                                  input int wb);
      erb_par = (wa % ERB_PAR_UNIT == 0) && (wb % ERB_PAR_UNIT == 0);
   endfunction : erb_par

   function automatic int erb_aw(input int cap,
                                 input int w);
      erb_aw = ($clog2(cap / w) < 1) ? 1 : $clog2(cap / w);
   endfunction : erb_aw

endpackage : erb_pkg
`default_nettype wire

// File: rtl/erb_out_stage.sv
// optional read-data output register with asynchronous clear
`default_nettype none
module erb_out_stage
   import erb_pkg::*;
#(
   parameter int W   = 36,
   parameter bit REG = 1'b1
) (
   input  wire logic         mclk,
   input  wire logic         clr_b,
   input  wire logic         ld,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] held;
   logic [W-1:0] next_held;

   always_comb begin
      next_held = ld ? d : held;
   end

   // clear acts at once, no clock needed
   always_ff @(posedge mclk or negedge clr_b) begin
      if (!clr_b) begin
         held <= '0;
      end else begin
         held <= next_held;
      end
   end

   // bypass saves a cycle but exposes the raw array path
   assign q = REG ? held : d;

endmodule : erb_out_stage
`default_nettype wire

// File: rtl/erb_ram_top.sv
// configurable synchronous embedded ram block, two ports on one clock
//
// Functional notes
// - three sizes: 32x18, 128x36, 4Kx144; power-of-two and x9 widths
// - medium and large: true dual port, any read/write mix per port
// - simple dual port: read plus write; collision gives old or unknown
// - single port: no simultaneous read/write; new data shows on q (a_q only, not b_q of two single ports)
// - clear hits input and output regs, large block outputs only
// - all inputs registered; write strobe timed from port clock
// - output registers optional; bypass gives one cycle less latency
// - small/medium simple dual port: flow-through, read regs on fall edge
// - medium block hosts two single ports, each half the capacity
// - dual-port modes allow different widths on the two ports
// - input clear shows at next edge (at once while a write is held); output clear shows at once
//
// Design decisions made here: the plain strobed port and the register addresses.
`default_nettype none
module erb_ram_top
   import erb_pkg::*;
#(
   parameter erb_size_type SIZE    = ERB_MEDIUM,
   parameter erb_mode_type MODE    = ERB_TRUE_DP,
   parameter int           WA      = 36,
   parameter int           WB      = 36,
   parameter bit           OREG_A  = 1'b1,
   parameter bit           OREG_B  = 1'b1,
   parameter bit           RDW_OLD = 1'b1,
   parameter bit           FLOW    = 1'b0,
   parameter int           AWA     = erb_aw(erb_cap(SIZE, erb_par(WA, WB)),
                                            WA),
   parameter int           AWB     = erb_aw(erb_cap(SIZE, erb_par(WA, WB)),
                                            WB)
) (
   input  wire logic           mclk,
   input  wire logic           rst_b,
   input  wire logic [AWA-1:0] a_addr,
   input  wire logic [WA-1:0]  a_din,
   input  wire logic           a_wren,
   input  wire logic           a_rden,
   output logic      [WA-1:0]  a_q,
   input  wire logic [AWB-1:0] b_addr,
   input  wire logic [WB-1:0]  b_din,
   input  wire logic           b_wren,
   input  wire logic           b_rden,
   output logic      [WB-1:0]  b_q
);

   // static configuration, fixed at elaboration
   localparam bit LARGE = (SIZE == ERB_LARGE);
   localparam int CAP   = erb_cap(SIZE, erb_par(WA, WB));
   localparam bit TWO   = (MODE == ERB_TWO_SP) && !LARGE;
   localparam int SPAN  = TWO ? CAP / 2 : CAP;
   localparam int BASEB = TWO ? CAP / 2 : 0;
   localparam bit FT    = FLOW && (MODE == ERB_SIMPLE_DP) && !LARGE;
   // large block ignores the clear on its input side
   localparam bit INCLR = !LARGE;

   // port b may write only where it owns a write path
   localparam bit BWR = (MODE == ERB_TRUE_DP) || TWO;
   localparam bit BON = (MODE != ERB_SINGLE);

   logic in_clr_b;
   assign in_clr_b = rst_b | !INCLR;

   // bit offset of a word, wrapped inside the port's span
   function automatic int word_off(input int addr,
                                   input int w,
                                   input int base);
      word_off = base + ((addr * w) % SPAN);
   endfunction : word_off

   // true when two bit ranges of the array share a bit
   function automatic bit overlap(input int off1,
                                  input int w1,
                                  input int off2,
                                  input int w2);
      overlap = (off1 < off2 + w2) && (off2 < off1 + w1);
   endfunction : overlap

   // ---------------- input registers ----------------
   logic [AWA-1:0] a_addr_r;
   logic [WA-1:0]  a_din_r;
   logic           a_wren_r;
   logic           a_rden_r;
   logic [AWB-1:0] b_addr_r;
   logic [WB-1:0]  b_din_r;
   logic           b_wren_r;
   logic           b_rden_p;

   logic [AWA-1:0] next_a_addr;
   logic [WA-1:0]  next_a_din;
   logic           next_a_wren;
   logic           next_a_rden;
   logic [AWB-1:0] next_b_addr;
   logic [WB-1:0]  next_b_din;
   logic           next_b_wren;
   logic           next_b_rden;

   always_comb begin
      next_a_addr = a_addr;
      next_a_din  = a_din;
      next_a_wren = a_wren;
      next_a_rden = a_rden;
      next_b_addr = b_addr;
      next_b_din  = b_din;
      next_b_wren = b_wren & BWR;
      next_b_rden = b_rden & BON;
   end

   // input clear is immediate but the array answers only on the next edge
   always_ff @(posedge mclk or negedge in_clr_b) begin
      if (!in_clr_b) begin
         a_addr_r <= '0;
         a_din_r  <= '0;
         a_wren_r <= 1'b0;
         a_rden_r <= 1'b0;
         b_addr_r <= '0;
         b_din_r  <= '0;
         b_wren_r <= 1'b0;
         b_rden_p <= 1'b0;
      end else begin
         a_addr_r <= next_a_addr;
         a_din_r  <= next_a_din;
         a_wren_r <= next_a_wren;
         a_rden_r <= next_a_rden;
         b_addr_r <= next_b_addr;
         b_din_r  <= next_b_din;
         b_wren_r <= next_b_wren;
         b_rden_p <= next_b_rden;
      end
   end

   // read-side address copies: a clear reaches the array read only at the
   // next edge, so an unregistered output jumps mid-cycle only when a registered write enable is cleared
   logic [AWA-1:0] a_look;
   logic [AWB-1:0] b_look;
   logic [AWA-1:0] next_a_look;
   logic [AWB-1:0] next_b_look;

   always_comb begin
      next_a_look = in_clr_b ? next_a_addr : '0;
      next_b_look = in_clr_b ? next_b_addr : '0;
   end

   always_ff @(posedge mclk) begin
      a_look <= next_a_look;
      b_look <= next_b_look;
   end

   // flow-through copy of the read side, taken on the falling edge
   logic [AWB-1:0] b_raddr_n;
   logic           b_rden_n;
   logic [AWB-1:0] next_b_raddr_n;
   logic           next_b_rden_n;

   always_comb begin
      next_b_raddr_n = in_clr_b ? next_b_addr : '0;
      next_b_rden_n  = in_clr_b & next_b_rden;
   end

   // clear lands on the falling edge, the first edge this path answers to
   always_ff @(negedge mclk) begin
      b_raddr_n <= next_b_raddr_n;
      b_rden_n  <= next_b_rden_n;
   end

   logic [AWB-1:0] b_raddr;
   logic           b_rden_r;
   assign b_raddr  = FT ? b_raddr_n : b_look;
   assign b_rden_r = FT ? b_rden_n : b_rden_p;

   // ---------------- storage ----------------
   logic [CAP-1:0] mem;
   logic [CAP-1:0] next_mem;
   int             a_off;
   int             a_roff;
   int             b_woff;
   int             b_roff;

   assign a_off  = word_off(int'(a_addr_r), WA, 0);
   assign a_roff = word_off(int'(a_look), WA, 0);
   assign b_woff = word_off(int'(b_addr_r), WB, BASEB);
   assign b_roff = word_off(int'(b_raddr), WB, BASEB);

   // self-timed strobe: the registered enable commits at the next edge
   always_comb begin
      next_mem = mem;
      if (a_wren_r) begin
         for (int i = 0; i < WA; i++) begin
            next_mem[a_off + i] = a_din_r[i];
         end
      end
      // port b lands last, so it wins a same-cycle write collision
      if (b_wren_r) begin
         for (int i = 0; i < WB; i++) begin
            next_mem[b_woff + i] = b_din_r[i];
         end
      end
   end

   // contents are never cleared; a large block must be filled by user logic
   always_ff @(posedge mclk) begin
      mem <= next_mem;
   end

   // ---------------- read paths ----------------
   logic [WA-1:0] a_rd;
   logic [WB-1:0] b_rd;
   logic          clash;
   logic          clash_a;

   assign clash   = a_wren_r && overlap(a_off, WA, b_roff, WB);
   // in true dual port, port a may read what port b is writing
   assign clash_a = b_wren_r && overlap(b_woff, WB, a_roff, WA);

   always_comb begin
      for (int i = 0; i < WA; i++) begin
         a_rd[i] = mem[a_roff + i];
      end
      if (clash_a && (!RDW_OLD || LARGE)) begin
         a_rd = 'x;
      end
      // a write on the same port shows its new data at once
      if (a_wren_r) begin
         a_rd = a_din_r;
      end
   end

   always_comb begin
      for (int i = 0; i < WB; i++) begin
         b_rd[i] = mem[b_roff + i];
      end
      // array still holds old data here; the unknown option drops it
      if (clash && (!RDW_OLD || LARGE)) begin
         b_rd = 'x;
      end
   end

   // ---------------- output stages ----------------
   // output clear reaches every size and shows without a clock
   erb_out_stage #(
      .W   (WA),
      .REG (OREG_A)
   ) u_out_a (
      .mclk  (mclk),
      .clr_b (rst_b),
      .ld    (a_rden_r | a_wren_r),
      .d     (a_rd),
      .q     (a_q)
   );

   erb_out_stage #(
      .W   (WB),
      .REG (OREG_B && !FT)
   ) u_out_b (
      .mclk  (mclk),
      .clr_b (rst_b),
      .ld    (b_rden_r),
      .d     (b_rd),
      .q     (b_q)
   );

endmodule : erb_ram_top
`default_nettype wire

// File: test/erb_ram_props.sv
// concurrent checks on the embedded ram block ports
`default_nettype none
module erb_ram_props #(
   parameter int WA  = 36,
   parameter int WB  = 36,
   parameter int AWA = 7,
   parameter int AWB = 7
) (
   input wire logic           mclk,
   input wire logic           rst_b,
   input wire logic [AWA-1:0] a_addr,
   input wire logic [WA-1:0]  a_din,
   input wire logic           a_wren,
   input wire logic           a_rden,
   input wire logic [WA-1:0]  a_q,
   input wire logic [AWB-1:0] b_addr,
   input wire logic [WB-1:0]  b_din,
   input wire logic           b_wren,
   input wire logic           b_rden,
   input wire logic [WB-1:0]  b_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_wr_echo: assert property (a_wren |-> ##2 a_q == $past(a_din, 2))
      else $error("port a write echo wrong");
   a_a_hold: assert property (!a_wren && !a_rden |-> ##2 $stable(a_q))
      else $error("port a output moved while idle");
   a_b_hold: assert property (!b_rden |-> ##2 $stable(b_q))
      else $error("port b output moved while idle");
   a_out_clear: assert property ($rose(rst_b) |->
      a_q == '0 && b_q == '0)
      else $error("outputs not cleared");
   a_cross_ab: assert property (a_wren ##3 (b_rden && !b_wren &&
      b_addr == $past(a_addr, 3)) |-> ##2 b_q == $past(a_din, 5))
      else $error("port b read of a write wrong");
   a_cross_ba: assert property (b_wren ##3 (a_rden && !a_wren &&
      a_addr == $past(b_addr, 3)) |-> ##2 a_q == $past(b_din, 5))
      else $error("port a read of b write wrong");
   a_self_a: assert property (a_wren ##3 (a_rden && !a_wren &&
      a_addr == $past(a_addr, 3)) |-> ##2 a_q == $past(a_din, 5))
      else $error("port a readback wrong");
   a_self_b: assert property (b_wren ##3 (b_rden && !b_wren &&
      b_addr == $past(b_addr, 3)) |-> ##2 b_q == $past(b_din, 5))
      else $error("port b readback wrong");
endmodule : erb_ram_props
`default_nettype wire

// File: test/erb_ram_top_test.sv
// self-checking bench for the embedded ram block
`default_nettype none
module erb_ram_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        a_wren = 1'b0, a_rden = 1'b0, go = 1'b0, wr = 1'b0;
   logic [6:0]  a_addr = 7'h00, addr = 7'h00, b_addr;
   logic [35:0] a_din = 36'h0, din = 36'h0, b_din, a_q, b_q;
   logic        b_wren, b_rden;
   int          err_total = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   always #2 mclk = ~mclk;
   erb_ram_top u_dut (.mclk(mclk), .rst_b(rst_b), .a_addr(a_addr),
      .a_din(a_din), .a_wren(a_wren), .a_rden(a_rden), .a_q(a_q),
      .b_addr(b_addr), .b_din(b_din), .b_wren(b_wren), .b_rden(b_rden),
      .b_q(b_q));
   erb_user_b u_user (.go(go), .wr(wr), .addr(addr), .din(din),
      .b_addr(b_addr), .b_din(b_din), .b_wren(b_wren), .b_rden(b_rden));
   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // one request on port a or b, output looked at two edges on
   task automatic op(input bit pb, input bit w, input logic [6:0] ad,
                     input logic [35:0] d, input logic [35:0] exp);
      @(posedge mclk);
      go <= pb;
      wr <= w;
      addr <= ad;
      din <= d;
      a_wren <= ~pb & w;
      a_rden <= ~pb & ~w;
      a_addr <= ad;
      a_din <= d;
      @(posedge mclk);
      go <= 1'b0;
      a_wren <= 1'b0;
      a_rden <= 1'b0;
      a_addr <= ~ad;
      a_din <= ~d;
      @(posedge mclk);
      #1;
      if (!(pb && w)) check(pb ? b_q : a_q, exp);
   endtask : op
   task automatic t_dual();
      logic [35:0] d;
      for (int i = 0; i < 4; i++) begin
         d = 36'h912340000 + 36'(i);
         op(1'b0, 1'b1, 7'h7f - 7'(i), d, d);
         op(1'b1, 1'b0, 7'h7f - 7'(i), 36'h0, d);
         op(1'b1, 1'b1, 7'(i), ~d, 36'h0);
         op(1'b0, 1'b0, 7'(i), 36'h0, ~d);
      end
   endtask : t_dual
   task automatic t_hold();
      op(1'b1, 1'b1, 7'h40, 36'h0c0ffee00, 36'h0);
      op(1'b1, 1'b0, 7'h40, 36'h0, 36'h0c0ffee00);
      op(1'b0, 1'b1, 7'h41, 36'h5a5a5a5a5, 36'h5a5a5a5a5);
      op(1'b0, 1'b0, 7'h41, 36'h0, 36'h5a5a5a5a5);
      repeat (3) @(posedge mclk);
      #1;
      check(b_q, 36'h0c0ffee00);
   endtask : t_hold
   // rom use: load once, then only reads with both write enables low
   task automatic t_rom();
      op(1'b0, 1'b1, 7'h30, 36'hfedcba987, 36'hfedcba987);
      repeat (3) begin
         op(1'b1, 1'b0, 7'h30, 36'h0, 36'hfedcba987);
         op(1'b0, 1'b0, 7'h30, 36'h0, 36'hfedcba987);
      end
   endtask : t_rom
   task automatic t_clear();
      @(posedge mclk);
      rst_b <= 1'b0;
      #1;
      check(a_q, 36'h0);
      check(b_q, 36'h0);
      @(posedge mclk);
      rst_b <= 1'b1;
      // contents survive the clear
      op(1'b1, 1'b0, 7'h40, 36'h0, 36'h0c0ffee00);
   endtask : t_clear
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      #1;
      check(a_q, 36'h0);
      check(b_q, 36'h0);
      t_dual();
      t_hold();
      t_rom();
      t_clear();
      test_done();
   end
   // run needs about 100 cycles; far above that means a hang
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_total++;
         test_done();
      end
   end
endmodule : erb_ram_top_test
bind erb_ram_top erb_ram_props #(.WA(WA), .WB(WB), .AWA(AWA), .AWB(AWB))
   u_props (.mclk(mclk), .rst_b(rst_b), .a_addr(a_addr), .a_din(a_din),
   .a_wren(a_wren), .a_rden(a_rden), .a_q(a_q), .b_addr(b_addr),
   .b_din(b_din), .b_wren(b_wren), .b_rden(b_rden), .b_q(b_q));
`default_nettype wire

// File: test/erb_user_b.sv
// user logic model driving port b of the ram block
`default_nettype none
module erb_user_b (
   input  wire logic        go,
   input  wire logic        wr,
   input  wire logic [6:0]  addr,
   input  wire logic [35:0] din,
   output logic      [6:0]  b_addr,
   output logic      [35:0] b_din,
   output logic             b_wren,
   output logic             b_rden
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle lines flip so a stale value never passes for a live one
   assign b_wren = go & wr;
   assign b_rden = go & ~wr;
   assign b_addr = go ? addr : ~addr;
   assign b_din  = go ? din : ~din;
endmodule : erb_user_b
`default_nettype wire
